// ==== rtl/iac_defines.svh ====
// register offsets, field positions, reset values and timing counts
// included by iac_addr_cmp and iac_top of the two-wire configuration block
`ifndef IAC_DEFINES_SVH
`define IAC_DEFINES_SVH
`define IAC_OFF_CTRL2      12'h004
`define IAC_OFF_OADDR1     12'h008
`define IAC_OFF_OADDR2     12'h00c
`define IAC_OFF_EVSTS      12'h020
`define IAC_OFF_EVMASK     12'h024
`define IAC_OFF_FLAGS      12'h028
`define IAC_CTRL2_WMASK    16'h1f3f
`define IAC_OADDR1_WMASK   16'hc3ff
`define IAC_OADDR2_WMASK   16'h00ff
`define IAC_RST16          16'h0000
`define IAC_B_LAST         12
`define IAC_B_DMA_REQUEST_ENABLE        11
`define IAC_B_BUFIE        10
`define IAC_B_EVTIE        9
`define IAC_B_ERRIE        8
`define IAC_F_FREQ_HI      5
`define IAC_B_TENBIT       15
`define IAC_B_DUAL         0
`define IAC_A7_HI          7
`define IAC_A7_LO          1
`define IAC_A10_HI         9
`define IAC_A10_LO         8
`define IAC_HDR_HI         7
`define IAC_HDR_LO         3
`define IAC_HDR_A_HI       2
`define IAC_HDR10          5'h1e
`define IAC_BIT_LAST       4'h7
`define IAC_FREQ_MIN       6'h02
`define IAC_FREQ_MAX       6'h24
`define IAC_EV_W           4
`define IAC_EV_EVT         0
`define IAC_EV_ERR         1
`define IAC_EV_MATCH       2
`define IAC_EV_LAST        3
`endif

// ==== rtl/iac_pkg.sv ====
// types shared by the two-wire configuration block
// no assumptions beyond the defines header
package iac_pkg;
   typedef enum logic [1:0] {
      IAC_ADDR_IDLE = 2'b00,
      IAC_ADDR_SHIFT = 2'b01,
      IAC_ADDR_DONE = 2'b10
   } iac_addr_state_t;
endpackage

// ==== rtl/iac_sync.sv ====
// two-flop synchroniser for inputs from outside the clock domain
// assumes destination clock mclk_in
`timescale 1ns/1ps
module iac_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_r;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         // idle level of pulled-up lines, so no false edge follows reset
         s1_r  <= '1;
         q_out <= '1;
      end else begin
         s1_r  <= d_in;
         q_out <= s1_r;
      end
   end
endmodule // iac_sync

// ==== rtl/iac_addr_cmp.sv ====
// shifts an address byte in from the bus and compares it with the own addresses
// assumes scl/sda already synchronised; frame begins at start_in pulse
`timescale 1ns/1ps
`include "iac_defines.svh"
module iac_addr_cmp (
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        start_in,
   input  wire logic        scl_rise_in,
   input  wire logic        sda_in,
   input  wire logic [15:0] oaddr1_in,
   input  wire logic [15:0] oaddr2_in,
   output logic             match_out,
   output logic             done_out
);
   iac_pkg::iac_addr_state_t st_r;
   logic [7:0]               sh_r;
   logic [3:0]               cnt_r;
   logic                     ten_bit;
   logic                     hit_pri;
   logic                     hit_alt;
   logic                     hit_ten;
   logic [7:0]               byte_v;

   assign byte_v  = {sh_r[6:0], sda_in};
   assign ten_bit = oaddr1_in[`IAC_B_TENBIT];
   // 7-bit match: ignores oaddr1 bits 9:8 and 0
   assign hit_pri = (byte_v[`IAC_A7_HI:`IAC_A7_LO] == oaddr1_in[`IAC_A7_HI:`IAC_A7_LO]);
   assign hit_alt = oaddr2_in[`IAC_B_DUAL] && !ten_bit
                    && (byte_v[`IAC_A7_HI:`IAC_A7_LO] == oaddr2_in[`IAC_A7_HI:`IAC_A7_LO]);
   // 10-bit header 11110xx carries address bits 9:8
   assign hit_ten = (byte_v[`IAC_HDR_HI:`IAC_HDR_LO] == `IAC_HDR10)
                    && (byte_v[`IAC_HDR_A_HI:`IAC_A7_LO] == oaddr1_in[`IAC_A10_HI:`IAC_A10_LO]);

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r      <= iac_pkg::IAC_ADDR_IDLE;
         sh_r      <= 8'h00;
         cnt_r     <= 4'h0;
         match_out <= 1'b0;
         done_out  <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (st_r)
            iac_pkg::IAC_ADDR_IDLE: begin
               cnt_r <= 4'h0;
               if (start_in) begin
                  st_r      <= iac_pkg::IAC_ADDR_SHIFT;
                  match_out <= 1'b0;
               end
            end
            iac_pkg::IAC_ADDR_SHIFT: begin
               if (start_in) begin
                  cnt_r <= 4'h0;
               end else if (scl_rise_in) begin
                  sh_r  <= byte_v;
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `IAC_BIT_LAST) begin
                     // only the header byte is checked in 10-bit mode
                     match_out <= ten_bit ? hit_ten : (hit_pri || hit_alt);
                     done_out  <= 1'b1;
                     st_r      <= iac_pkg::IAC_ADDR_DONE;
                  end
               end
            end
            iac_pkg::IAC_ADDR_DONE: begin
               st_r <= iac_pkg::IAC_ADDR_IDLE;
            end
            default: begin
               st_r <= iac_pkg::IAC_ADDR_IDLE;
            end
         endcase
      end
   end
endmodule // iac_addr_cmp

// ==== rtl/iac_top.sv ====
// configuration part of a two-wire controller: control two, own addresses,
// interrupt sources, dma request gating, apb slave and event status.
// assumes flags come from controller logic on mclk_in; scl/sda are pins.
//
// Notes on behaviour
// - with last marker set in master receive, next dma end is final, nack last byte
// - transmit-empty and receive-not-empty interrupt only with buffer and event enables
// - event enable passes start, address, ten-bit header and stop flags
// - byte-finished flag raises event interrupt without buffer conditions
// - error enable passes bus, arbitration, ack, overrun, check, timeout, alert
// - six-bit clock field valid 2 to 36 MHz, other codes mean disabled
// - addressing mode bit selects 7-bit or 10-bit recognition
// - bits 9:8 and 0 form the 10-bit address, ignored in 7-bit mode
// - primary 7-bit address comes from bits 7:1
// - alternate address in bits 7:1 of the second own-address register
// - dual enable zero matches primary only, one matches both
// - dual recognition only in 7-bit mode
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "iac_defines.svh"
module iac_top (
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   // apb
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // status flags from the controller core
   input  wire logic        transmit_empty_flag_in,
   input  wire logic        receive_not_empty_flag_in,
   input  wire logic        start_sent_flag_in,
   input  wire logic        address_matched_flag_in,
   input  wire logic        ten_bit_header_flag_in,
   input  wire logic        stop_detected_flag_in,
   input  wire logic        byte_finished_flag_in,
   input  wire logic        bus_error_flag_in,
   input  wire logic        arbitration_lost_flag_in,
   input  wire logic        acknowledge_failure_flag_in,
   input  wire logic        overrun_flag_in,
   input  wire logic        packet_check_error_flag_in,
   input  wire logic        timeout_flag_in,
   input  wire logic        alert_flag_in,
   // dma
   input  wire logic        master_receive_in,
   input  wire logic        dma_transfer_end_in,
   output logic             dma_tx_req_out,
   output logic             dma_rx_req_out,
   output logic             nack_last_out,
   // bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   // to the core
   output logic             address_hit_out,
   output logic             clock_valid_out,
   output logic [5:0]       periph_clock_mhz_out,
   output logic             event_irq_out,
   output logic             error_irq_out,
   output logic             irq_out
);
   logic [15:0]             ctrl2_r;
   logic [15:0]             oaddr1_r;
   logic [15:0]             oaddr2_r;
   logic [`IAC_EV_W-1:0]    evsts_r;
   logic [`IAC_EV_W-1:0]    evmask_r;
   logic [`IAC_EV_W-1:0]    ev_set;
   logic                    wr_en;
   logic                    rd_en;
   logic                    addr_ok;
   logic [31:0]             rdata_nxt;
   logic                    evt_src;
   logic                    err_src;
   logic                    evt_irq_d_r;
   logic                    err_irq_d_r;
   logic                    last_pending_r;
   logic [1:0]              bus_s;
   logic                    scl_d_r;
   logic                    sda_d_r;
   logic                    scl_rise;
   logic                    start_cond;
   logic                    cmp_match;
   logic                    cmp_done;
   logic [5:0]              freq;

   // field decode used by both clock-valid output and status readback
   function automatic logic freq_ok(input logic [5:0] f);
      freq_ok = (f >= `IAC_FREQ_MIN) && (f <= `IAC_FREQ_MAX);
   endfunction

   assign freq = ctrl2_r[`IAC_F_FREQ_HI:0];

   // apb decode: single-cycle access phase, no wait states
   assign wr_en = psel_in && penable_in && pwrite_in;
   // read data taken in setup so it stands through the access phase
   assign rd_en = psel_in && !penable_in && !pwrite_in;
   always_comb begin
      addr_ok   = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (paddr_in == `IAC_OFF_CTRL2) begin
         rdata_nxt = {16'h0000, ctrl2_r};
      end else if (paddr_in == `IAC_OFF_OADDR1) begin
         rdata_nxt = {16'h0000, oaddr1_r};
      end else if (paddr_in == `IAC_OFF_OADDR2) begin
         rdata_nxt = {16'h0000, oaddr2_r};
      end else if (paddr_in == `IAC_OFF_EVSTS) begin
         rdata_nxt = {28'h0000000, evsts_r};
      end else if (paddr_in == `IAC_OFF_EVMASK) begin
         rdata_nxt = {28'h0000000, evmask_r};
      end else if (paddr_in == `IAC_OFF_FLAGS) begin
         rdata_nxt = {29'h00000000, last_pending_r, cmp_match, freq_ok(freq)};
      end else begin
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !addr_ok;
         if (rd_en) begin
            prdata_out <= rdata_nxt;
         end
      end
   end

   // config registers; reserved bits kept at zero except bit 14 which software sets
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl2_r  <= `IAC_RST16;
         oaddr1_r <= `IAC_RST16;
         oaddr2_r <= `IAC_RST16;
         evmask_r <= '0;
      end else if (wr_en && pready_out) begin
         if (paddr_in == `IAC_OFF_CTRL2) begin
            ctrl2_r <= pwdata_in[15:0] & `IAC_CTRL2_WMASK;
         end else if (paddr_in == `IAC_OFF_OADDR1) begin
            oaddr1_r <= pwdata_in[15:0] & `IAC_OADDR1_WMASK;
         end else if (paddr_in == `IAC_OFF_OADDR2) begin
            oaddr2_r <= pwdata_in[15:0] & `IAC_OADDR2_WMASK;
         end else if (paddr_in == `IAC_OFF_EVMASK) begin
            evmask_r <= pwdata_in[`IAC_EV_W-1:0];
         end
      end
   end

   // interrupt sources
   always_comb begin
      evt_src = ctrl2_r[`IAC_B_EVTIE] && (
                   start_sent_flag_in || address_matched_flag_in
                || ten_bit_header_flag_in || stop_detected_flag_in
                || byte_finished_flag_in
                || (ctrl2_r[`IAC_B_BUFIE]
                    && (transmit_empty_flag_in || receive_not_empty_flag_in)));
      err_src = ctrl2_r[`IAC_B_ERRIE] && (
                   bus_error_flag_in || arbitration_lost_flag_in
                || acknowledge_failure_flag_in || overrun_flag_in
                || packet_check_error_flag_in || timeout_flag_in
                || alert_flag_in);
   end

   // registered every cycle; one cycle late, keeps outputs glitch free
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         event_irq_out <= 1'b0;
         error_irq_out <= 1'b0;
         evt_irq_d_r   <= 1'b0;
         err_irq_d_r   <= 1'b0;
      end else begin
         event_irq_out <= evt_src;
         error_irq_out <= err_src;
         evt_irq_d_r   <= event_irq_out;
         err_irq_d_r   <= error_irq_out;
      end
   end

   // dma requests
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dma_tx_req_out <= 1'b0;
         dma_rx_req_out <= 1'b0;
      end else begin
         dma_tx_req_out <= ctrl2_r[`IAC_B_DMA_REQUEST_ENABLE] && transmit_empty_flag_in;
         dma_rx_req_out <= ctrl2_r[`IAC_B_DMA_REQUEST_ENABLE] && receive_not_empty_flag_in;
      end
   end

   // last-transfer marking: pending while last bit set in master receive; a dma end then sets nack, held until receive drops
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         last_pending_r <= 1'b0;
         nack_last_out  <= 1'b0;
      end else begin
         last_pending_r <= ctrl2_r[`IAC_B_LAST] && master_receive_in;
         if (!master_receive_in) begin
            nack_last_out <= 1'b0;
         end else if (dma_transfer_end_in && last_pending_r) begin
            nack_last_out <= 1'b1;
         end
      end
   end

   // pins cross into mclk domain; limitation: scl must stay well below mclk/4
   iac_sync #(.W(2)) u_sync (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .d_in    ({scl_in, sda_in}),
      .q_out   (bus_s)
   );

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= bus_s[1];
         sda_d_r <= bus_s[0];
      end
   end

   assign scl_rise   = bus_s[1] && !scl_d_r;
   assign start_cond = bus_s[1] && scl_d_r && sda_d_r && !bus_s[0];

   iac_addr_cmp u_cmp (
      .mclk_in     (mclk_in),
      .rstn_in     (rstn_in),
      .start_in    (start_cond),
      .scl_rise_in (scl_rise),
      .sda_in      (bus_s[0]),
      .oaddr1_in   (oaddr1_r),
      .oaddr2_in   (oaddr2_r),
      .match_out   (cmp_match),
      .done_out    (cmp_done)
   );

   // sticky event status; set wins over write-one clear
   assign ev_set = {(last_pending_r && dma_transfer_end_in),
                    (cmp_done && cmp_match),
                    (error_irq_out && !err_irq_d_r),
                    (event_irq_out && !evt_irq_d_r)};

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evsts_r <= '0;
      end else if (wr_en && pready_out && paddr_in == `IAC_OFF_EVSTS) begin
         evsts_r <= (evsts_r & ~pwdata_in[`IAC_EV_W-1:0]) | ev_set;
      end else begin
         evsts_r <= evsts_r | ev_set;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_out              <= 1'b0;
         address_hit_out      <= 1'b0;
         clock_valid_out      <= 1'b0;
         periph_clock_mhz_out <= 6'h00;
      end else begin
         irq_out              <= |(evsts_r & evmask_r);
         address_hit_out      <= cmp_done && cmp_match;
         clock_valid_out      <= freq_ok(freq);
         periph_clock_mhz_out <= freq;
      end
   end
endmodule // iac_top

// ==== sim/iac_checker.sv ====
// checker: port assertions of the two-wire configuration block
// assumes a bind to iac_top, one clock domain
`timescale 1ns/1ps
module iac_checker (
   input wire logic       mclk_in,
   input wire logic       rstn_in,
   input wire logic       psel_in,
   input wire logic       penable_in,
   input wire logic       pready_out,
   input wire logic       transmit_empty_flag_in,
   input wire logic       receive_not_empty_flag_in,
   input wire logic       start_sent_flag_in,
   input wire logic       address_matched_flag_in,
   input wire logic       ten_bit_header_flag_in,
   input wire logic       stop_detected_flag_in,
   input wire logic       byte_finished_flag_in,
   input wire logic       bus_error_flag_in,
   input wire logic       arbitration_lost_flag_in,
   input wire logic       acknowledge_failure_flag_in,
   input wire logic       overrun_flag_in,
   input wire logic       packet_check_error_flag_in,
   input wire logic       timeout_flag_in,
   input wire logic       alert_flag_in,
   input wire logic       master_receive_in,
   input wire logic       dma_transfer_end_in,
   input wire logic       dma_tx_req_out,
   input wire logic       dma_rx_req_out,
   input wire logic       nack_last_out,
   input wire logic       clock_valid_out,
   input wire logic [5:0] periph_clock_mhz_out,
   input wire logic       event_irq_out,
   input wire logic       error_irq_out
);
   logic ev_any;
   logic er_any;
   assign ev_any = transmit_empty_flag_in | receive_not_empty_flag_in | start_sent_flag_in
                 | address_matched_flag_in | ten_bit_header_flag_in | stop_detected_flag_in | byte_finished_flag_in;
   assign er_any = bus_error_flag_in | arbitration_lost_flag_in | acknowledge_failure_flag_in | overrun_flag_in
                 | packet_check_error_flag_in | timeout_flag_in | alert_flag_in;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_setup; psel_in && !penable_in; endsequence
   sequence s_access; psel_in && penable_in && pready_out; endsequence
   property p_ready; s_setup |=> s_access; endproperty
   property p_pulse; pready_out |=> !pready_out; endproperty
   property p_dma_tx; dma_tx_req_out |-> $past(transmit_empty_flag_in); endproperty
   property p_dma_rx; dma_rx_req_out |-> $past(receive_not_empty_flag_in); endproperty
   property p_evt; event_irq_out |-> $past(ev_any); endproperty
   property p_err; error_irq_out |-> $past(er_any); endproperty
   property p_freq; clock_valid_out == (periph_clock_mhz_out inside {[6'h02:6'h24]}); endproperty
   property p_nack_set; $rose(nack_last_out) |-> $past(dma_transfer_end_in) && $past(master_receive_in); endproperty
   property p_nack_clr; !master_receive_in |=> !nack_last_out; endproperty
   a_ready: assert property (p_ready) else $error("no one-cycle ready");
   a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
   a_dma_tx: assert property (p_dma_tx) else $error("tx request without empty flag");
   a_dma_rx: assert property (p_dma_rx) else $error("rx request without data flag");
   a_evt: assert property (p_evt) else $error("event irq without source");
   a_err: assert property (p_err) else $error("error irq without source");
   a_freq: assert property (p_freq) else $error("clock valid mismatch");
   a_nack_set: assert property (p_nack_set) else $error("nack without dma end");
   a_nack_clr: assert property (p_nack_clr) else $error("nack held out of receive");
endmodule // iac_checker

bind iac_top iac_checker i_chk (.*);

// ==== sim/iac_bus_model.sv ====
// bus partner: a master that sends one address byte between start and stop
// assumes pull-ups; both lines stand high between frames
`timescale 1ns/1ps
module iac_bus_model (
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // 160 ns bit period; odd start offset keeps phase apart from the block clock
   task automatic send(input logic [7:0] b);
      #37 sda_out = 1'b0;
      #80 scl_out = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #40 sda_out = b[i];
         #40 scl_out = 1'b1;
         #80 scl_out = 1'b0;
      end
      #40 sda_out = 1'b1;
      #40 scl_out = 1'b1;
      #80 scl_out = 1'b0;
      #40 sda_out = 1'b0;
      #40 scl_out = 1'b1;
      #80 sda_out = 1'b1;
   endtask
endmodule // iac_bus_model

// ==== sim/iac_top_tb_top.sv ====
// self-checking bench of the configuration block, apb master and flag driver
// assumes the checker is bound by its own file
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t bad value %h", $time, (a)); end end
module iac_top_tb_top;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, err, scl, sda, hit, h;
   logic [13:0] flg = 14'h0;
   logic        mrx = 1'b0;
   logic        dend = 1'b0;
   logic        hit_seen = 1'b0;
   logic        txq, rxq, nack, cval, evi, eri, irq;
   logic [5:0]  mhz;
   int          fail_count = 0;
   int          checks = 0;
   int          cyc = 0;
   always #10 clk = ~clk;
   iac_bus_model i_bus (.scl_out(scl), .sda_out(sda));
   iac_top i_dut (.mclk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .transmit_empty_flag_in(flg[0]), .receive_not_empty_flag_in(flg[1]), .start_sent_flag_in(flg[2]),
      .address_matched_flag_in(flg[3]), .ten_bit_header_flag_in(flg[4]), .stop_detected_flag_in(flg[5]),
      .byte_finished_flag_in(flg[6]), .bus_error_flag_in(flg[7]), .arbitration_lost_flag_in(flg[8]),
      .acknowledge_failure_flag_in(flg[9]), .overrun_flag_in(flg[10]), .packet_check_error_flag_in(flg[11]),
      .timeout_flag_in(flg[12]), .alert_flag_in(flg[13]), .master_receive_in(mrx), .dma_transfer_end_in(dend),
      .dma_tx_req_out(txq), .dma_rx_req_out(rxq), .nack_last_out(nack), .scl_in(scl), .sda_in(sda),
      .address_hit_out(hit), .clock_valid_out(cval), .periph_clock_mhz_out(mhz), .event_irq_out(evi),
      .error_irq_out(eri), .irq_out(irq));
   always @(posedge clk) begin
      cyc++;
      if (hit) hit_seen <= 1'b1;
      if (cyc == 40000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one transfer; released only after pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      `CHK(n, 1)
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic fl(input logic [13:0] v);
      flg <= v;
      repeat (3) @(posedge clk);
   endtask
   // register lands at the access edge, registered outputs one edge later
   task automatic cfg(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge clk);
   endtask
   task automatic t_regs();
      logic [11:0] offs [3] = '{12'h004, 12'h008, 12'h00c};
      logic [31:0] msk [3] = '{32'h1f3f, 32'hc3ff, 32'h00ff};
      logic [31:0] keep [3] = '{32'h0, 32'h4000, 32'h0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, offs[i], 32'h0);
         `CHK(rd, 32'h0)
         apb(1'b1, offs[i], 32'hffffffff);
         apb(1'b0, offs[i], 32'h0);
         `CHK(rd, msk[i])
         apb(1'b1, offs[i], keep[i]);
      end
      apb(1'b1, 12'h010, 32'h1);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h010, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("t_regs done");
   endtask
   task automatic t_freq();
      logic [5:0] code [6] = '{6'h00, 6'h01, 6'h02, 6'h24, 6'h25, 6'h3f};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h004, {26'h0, code[i]});
         repeat (2) @(posedge clk);
         `CHK(mhz, code[i])
         `CHK(cval, code[i] >= 6'h02 && code[i] <= 6'h24)
      end
      $display("t_freq done");
   endtask
   task automatic t_irq();
      apb(1'b1, 12'h004, 32'h0200);
      fl(14'h0001);
      `CHK(evi, 1'b0)
      fl(14'h0002);
      `CHK(evi, 1'b0)
      cfg(12'h004, 32'h0600);
      `CHK(evi, 1'b1)
      apb(1'b1, 12'h004, 32'h0200);
      for (int i = 2; i < 7; i++) begin
         fl(14'h1 << i);
         `CHK({evi, eri}, 2'b10)
      end
      cfg(12'h004, 32'h0100);
      `CHK(evi, 1'b0)
      for (int i = 7; i < 14; i++) begin
         fl(14'h1 << i);
         `CHK({evi, eri}, 2'b01)
      end
      fl(14'h0);
      `CHK(eri, 1'b0)
      cfg(12'h024, 32'h2);
      `CHK(irq, 1'b1)
      apb(1'b1, 12'h020, 32'hf);
      apb(1'b0, 12'h020, 32'h0);
      `CHK({irq, rd[1]}, 2'b00)
      apb(1'b1, 12'h024, 32'h0);
      fl(14'h0080);
      apb(1'b0, 12'h020, 32'h0);
      `CHK({irq, rd[1]}, 2'b01)
      fl(14'h0);
      apb(1'b1, 12'h004, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_dma();
      fl(14'h0003);
      `CHK({txq, rxq}, 2'b00)
      apb(1'b1, 12'h004, 32'h0800);
      fl(14'h0001);
      `CHK({txq, rxq}, 2'b10)
      fl(14'h0002);
      `CHK({txq, rxq}, 2'b01)
      fl(14'h0);
      $display("t_dma done");
   endtask
   task automatic t_last();
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, 12'h004, m ? 32'h1000 : 32'h0);
         mrx <= 1'b1;
         @(posedge clk);
         dend <= 1'b1;
         @(posedge clk);
         dend <= 1'b0;
         repeat (2) @(posedge clk);
         `CHK(nack, m[0])
         apb(1'b0, 12'h028, 32'h0);
         `CHK(rd[2:0], {m[0], 2'b00})
         mrx <= 1'b0;
         repeat (2) @(posedge clk);
         `CHK(nack, 1'b0)
      end
      $display("t_last done");
   endtask
   task automatic try(input logic [15:0] o1, input logic [7:0] o2, input logic [7:0] b);
      apb(1'b1, 12'h008, {16'h0, o1});
      apb(1'b1, 12'h00c, {24'h0, o2});
      hit_seen <= 1'b0;
      i_bus.send(b);
      repeat (10) @(posedge clk);
      h = hit_seen;
   endtask
   task automatic t_addr();
      try(16'h4074, 8'h52, 8'h74);
      `CHK(h, 1'b1)
      try(16'h4375, 8'h52, 8'h74);
      `CHK(h, 1'b1)
      try(16'h4074, 8'h52, 8'h52);
      `CHK(h, 1'b0)
      try(16'h4074, 8'h53, 8'h52);
      `CHK(h, 1'b1)
      try(16'h4074, 8'h53, 8'h74);
      `CHK(h, 1'b1)
      try(16'hc274, 8'h53, 8'h52);
      `CHK(h, 1'b0)
      try(16'hc274, 8'h53, 8'hf4);
      `CHK(h, 1'b1)
      try(16'hc274, 8'h53, 8'h74);
      `CHK(h, 1'b0)
      $display("t_addr done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_freq();
      t_irq();
      t_dma();
      t_last();
      t_addr();
      conclude();
   end
endmodule // iac_top_tb_top
